// ===== pkg/wake_defines.svh
// register offsets, field positions, codes and reset values of the wake logic
`ifndef WAKE_DEFINES_SVH
`define WAKE_DEFINES_SVH
`define ADDR_CTRL 8'h10
`define ADDR_THRESH_CTRL 8'h13
`define ADDR_THRESH_CFG 8'h14
`define CTRL_PD_HI 6
`define CTRL_PD_LO 4
`define TC_MODE_BIT 7
`define TC_COMBINE_BIT 6
`define CFG_CNTEN_BIT 3
`define SEL_NONE0 3'h0
`define SEL_TH_X 3'h1
`define SEL_TH_Y 3'h2
`define SEL_TH_Z 3'h3
`define SEL_NONE1 3'h4
`define SEL_CNT_X 3'h5
`define SEL_CNT_Y 3'h6
`define SEL_CNT_Z 3'h7
`define FIELD_RESET 6'h00
`define BYTE_RESET 8'h00
`define MODE_RESET 2'h0
`define HITS_MAX 6'h3F
`endif

// ===== pkg/wake_pkg.sv
// types of the wake logic
package wake_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FIRST,
        ST_WATCH
    } watch_state_t;
endpackage

// ===== logic/axis_delta_detect.sv
// one axis: delta, threshold compare and detection counter
`timescale 1ns/100ps
`include "wake_defines.svh"
module axis_delta_detect #(
    parameter int SW = 12
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_first,
    input wire logic i_sample_valid,
    input wire logic [SW-1:0] i_sample,
    input wire logic i_baseline_mode,
    input wire logic i_cnt_en,
    input wire logic [5:0] i_threshold,
    input wire logic [5:0] i_count,
    output logic o_satisfied
);
    logic [SW-1:0] ref_q;
    logic [5:0] hits_q;
    logic sat_q;
    logic [SW:0] diff;
    logic [SW:0] mag;
    logic event_hit;
    logic [6:0] need;
    logic [6:0] hits_next;
    assign diff = {i_sample[SW-1], i_sample} - {ref_q[SW-1], ref_q};
    assign mag = diff[SW] ? (~diff + 1'b1) : diff;
    assign event_hit = i_sample_valid && !i_first
        && (mag > {{(SW-5){1'b0}}, i_threshold});
    assign need = {1'b0, i_count} + 7'h01;
    assign hits_next = {1'b0, hits_q} + 7'h01;
    assign o_satisfied = sat_q;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || i_first && !i_sample_valid) begin
            ref_q <= '0;
            hits_q <= `FIELD_RESET;
            sat_q <= 1'b0;
        end else if (i_sample_valid) begin
            // baseline keeps the first sample, moving window the last one
            if (i_first || !i_baseline_mode) begin
                ref_q <= i_sample;
            end
            if (i_first) begin
                hits_q <= `FIELD_RESET;
                sat_q <= 1'b0;
            end else if (event_hit) begin
                if (!i_cnt_en || hits_next >= need) begin
                    sat_q <= 1'b1;
                end
                // saturate so a long burst never wraps back below the need
                if (hits_q != `HITS_MAX) begin
                    hits_q <= hits_next[5:0];
                end
            end
        end
    end
endmodule

// ===== logic/shadow_regs.sv
// shadow registers reached through the 6-bit access field
`timescale 1ns/100ps
`include "wake_defines.svh"
module shadow_regs (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [2:0] i_sel,
    input wire logic i_wr,
    input wire logic [5:0] i_wdata,
    output logic [5:0] o_rdata,
    output logic [5:0] o_th_x,
    output logic [5:0] o_th_y,
    output logic [5:0] o_th_z,
    output logic [5:0] o_cnt_x,
    output logic [5:0] o_cnt_y,
    output logic [5:0] o_cnt_z
);
    logic [5:0] mem_q [0:7];
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            for (int i = 0; i < 8; i++) begin
                mem_q[i] <= `FIELD_RESET;
            end
        end else if (i_wr && i_sel != `SEL_NONE0 && i_sel != `SEL_NONE1) begin
            mem_q[i_sel] <= i_wdata;
        end
    end
    assign o_rdata = mem_q[i_sel]; // unused slots never written, read zero
    assign o_th_x = mem_q[`SEL_TH_X];
    assign o_th_y = mem_q[`SEL_TH_Y];
    assign o_th_z = mem_q[`SEL_TH_Z];
    assign o_cnt_x = mem_q[`SEL_CNT_X];
    assign o_cnt_y = mem_q[`SEL_CNT_Y];
    assign o_cnt_z = mem_q[`SEL_CNT_Z];
endmodule

// ===== logic/motion_wake_threshold_logic.sv
// top of the per-axis activity detection and wake combine logic
// Summary of operation
// - selector 010 reaches the Y threshold
// - selector 011 reaches the Z threshold
// - selector 101 reaches the X event count
// - selector 110 reaches the Y event count
// - selector 111 reaches the Z event count
// - required events equal stored count plus one
// - combine bit low: any active axis wakes
// - combine bit high: all active axes wake
// - powered-down axes drop out of combining
// - mode low: delta against previous sample
// - mode high: delta against stored baseline
// - event when axis delta exceeds threshold
// - baseline is first sample after watch entry
// - config low three bits pick shadow register
`timescale 1ns/100ps
`include "wake_defines.svh"
module motion_wake_threshold_logic #(
    parameter int SW = 12
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_watch_mode,
    input wire logic i_sample_valid,
    input wire logic [SW-1:0] i_sample_x,
    input wire logic [SW-1:0] i_sample_y,
    input wire logic [SW-1:0] i_sample_z,
    output logic [7:0] o_reg_rdata,
    output logic o_wake
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] ctrl_q;
    logic [1:0] tc_hi_q;
    logic [7:0] cfg_q;
    logic [7:0] rdata_q;
    logic wake_q;
    wake_pkg::watch_state_t state_q;
    wake_pkg::watch_state_t state_d;
    logic [5:0] sh_rdata;
    logic [5:0] th_x, th_y, th_z, cnt_x, cnt_y, cnt_z;
    logic [2:0] sat;
    logic [2:0] active;
    logic any_hit;
    logic all_hit;
    logic wake_d;
    logic first;
    logic sh_wr;
    logic [7:0] rd_mux;
    logic [2:0] addr_hit;
    logic ctrl_wr;
    logic cfg_wr;
    ////////////////////////////////////////////////////////////////////////
    // register port
    // one-hot decode shared by the write strobes and the read mux
    function automatic logic [2:0] decode_addr(input logic [7:0] a);
        logic [2:0] hit;
        hit[0] = a == `ADDR_CTRL;
        hit[1] = a == `ADDR_THRESH_CTRL;
        hit[2] = a == `ADDR_THRESH_CFG;
        return hit;
    endfunction
    assign addr_hit = decode_addr(i_reg_addr);
    assign ctrl_wr = i_reg_wr && addr_hit[0];
    assign sh_wr = i_reg_wr && addr_hit[1];
    assign cfg_wr = i_reg_wr && addr_hit[2];
    // unmapped addresses fall through to zero
    assign rd_mux = addr_hit[0] ? ctrl_q :
        addr_hit[1] ? {tc_hi_q, sh_rdata} :
        addr_hit[2] ? cfg_q : `BYTE_RESET;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ctrl_q <= `BYTE_RESET;
        end else if (ctrl_wr) begin
            ctrl_q <= i_reg_wdata;
        end
    end
    // only the mode and combine bits live here; the low six go to the shadows
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tc_hi_q <= `MODE_RESET;
        end else if (sh_wr) begin
            tc_hi_q <= i_reg_wdata[`TC_MODE_BIT:`TC_COMBINE_BIT];
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cfg_q <= `BYTE_RESET;
        end else if (cfg_wr) begin
            cfg_q <= i_reg_wdata;
        end
    end
    // read data is latched so it stands until the next read strobe
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rdata_q <= `BYTE_RESET;
        end else if (i_reg_rd) begin
            rdata_q <= rd_mux;
        end
    end
    shadow_regs u_shadow (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_sel(cfg_q[2:0]),
        .i_wr(sh_wr),
        .i_wdata(i_reg_wdata[5:0]),
        .o_rdata(sh_rdata),
        .o_th_x(th_x),
        .o_th_y(th_y),
        .o_th_z(th_z),
        .o_cnt_x(cnt_x),
        .o_cnt_y(cnt_y),
        .o_cnt_z(cnt_z)
    );
    ////////////////////////////////////////////////////////////////////////
    // watch sequencing: first sample after entry becomes the baseline
    always_comb begin
        state_d = state_q;
        case (state_q)
            wake_pkg::ST_IDLE: begin
                if (i_watch_mode && i_sample_valid) begin
                    // a sample on the entry edge is already the baseline
                    state_d = wake_pkg::ST_WATCH;
                end else if (i_watch_mode) begin
                    state_d = wake_pkg::ST_FIRST;
                end
            end
            wake_pkg::ST_FIRST: begin
                if (!i_watch_mode) begin
                    state_d = wake_pkg::ST_IDLE;
                end else if (i_sample_valid) begin
                    state_d = wake_pkg::ST_WATCH;
                end
            end
            wake_pkg::ST_WATCH: begin
                if (!i_watch_mode) begin
                    state_d = wake_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = wake_pkg::ST_IDLE;
            end
        endcase
    end
    assign first = state_q != wake_pkg::ST_WATCH;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_q <= wake_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // axes
    axis_delta_detect #(.SW(SW)) u_x (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_first(first),
        .i_sample_valid(i_sample_valid && i_watch_mode),
        .i_sample(i_sample_x),
        .i_baseline_mode(tc_hi_q[1]),
        .i_cnt_en(cfg_q[`CFG_CNTEN_BIT]),
        .i_threshold(th_x),
        .i_count(cnt_x),
        .o_satisfied(sat[0])
    );
    axis_delta_detect #(.SW(SW)) u_y (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_first(first),
        .i_sample_valid(i_sample_valid && i_watch_mode),
        .i_sample(i_sample_y),
        .i_baseline_mode(tc_hi_q[1]),
        .i_cnt_en(cfg_q[`CFG_CNTEN_BIT]),
        .i_threshold(th_y),
        .i_count(cnt_y),
        .o_satisfied(sat[1])
    );
    axis_delta_detect #(.SW(SW)) u_z (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_first(first),
        .i_sample_valid(i_sample_valid && i_watch_mode),
        .i_sample(i_sample_z),
        .i_baseline_mode(tc_hi_q[1]),
        .i_cnt_en(cfg_q[`CFG_CNTEN_BIT]),
        .i_threshold(th_z),
        .i_count(cnt_z),
        .o_satisfied(sat[2])
    );
    ////////////////////////////////////////////////////////////////////////
    // combine; with all axes down nothing can wake, even in and mode
    assign active = ~ctrl_q[`CTRL_PD_HI:`CTRL_PD_LO];
    assign any_hit = |(sat & active);
    assign all_hit = (|active) && ((sat & active) == active);
    assign wake_d = i_watch_mode && (tc_hi_q[0] ? all_hit : any_hit);
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= wake_d;
        end
    end
    assign o_reg_rdata = rdata_q;
    assign o_wake = wake_q;
endmodule

// ===== tb/motion_wake_chk.sv
// port checker of the wake logic
`timescale 1ns/100ps
module motion_wake_chk (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_watch_mode,
    input wire logic i_sample_valid,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_wake
);
    logic [2:0] sel_q;
    logic [2:0] pd_q;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////////
    // shadow of selector and power-down, only from writes seen here
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sel_q <= 3'h0;
            pd_q <= 3'h0;
        end else if (i_reg_wr && i_reg_addr == 8'h14) begin
            sel_q <= i_reg_wdata[2:0];
        end else if (i_reg_wr && i_reg_addr == 8'h10) begin
            pd_q <= i_reg_wdata[6:4];
        end
    end
    sequence s_wr_tc;
        i_reg_wr && i_reg_addr == 8'h13;
    endsequence
    sequence s_rd_tc;
        i_reg_rd && !i_reg_wr && i_reg_addr == 8'h13;
    endsequence
    ////////////////////////////////////////////////////////////////
    a_unmapped_read_zero: assert property (
        i_reg_rd && !(i_reg_addr inside {8'h10, 8'h13, 8'h14}) |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (
        !i_reg_rd |=> $stable(o_reg_rdata)) else $error("read data moved");
    a_none_sel_zero: assert property (
        s_rd_tc ##0 (sel_q == 3'h0 || sel_q == 3'h4) |=> o_reg_rdata[5:0] == 6'h00)
        else $error("empty selector read not zero");
    a_mode_bits_back: assert property (
        s_wr_tc ##2 s_rd_tc |=> o_reg_rdata[7:6] == $past(i_reg_wdata[7:6], 3))
        else $error("mode bits readback wrong");
    a_wake_needs_watch: assert property (
        !i_watch_mode ##1 !i_watch_mode |-> !o_wake) else $error("wake outside watch");
    // a register write may legally bring an already satisfied axis into play
    a_wake_after_sample: assert property (
        $rose(o_wake) && !$past(i_reg_wr, 2) |-> $past(i_sample_valid, 2)
        || $past(i_sample_valid, 3))
        else $error("wake without sample");
    a_all_down_quiet: assert property (
        pd_q == 3'h7 ##1 pd_q == 3'h7 |-> !o_wake) else $error("wake with all axes down");
    // a write one edge back reaches the wake flop only now, so it is excused
    a_wake_sticky: assert property (
        o_wake && i_watch_mode && !i_reg_wr && !$past(i_reg_wr) |=> o_wake)
        else $error("wake dropped");
endmodule

bind motion_wake_threshold_logic motion_wake_chk i_motion_wake_chk (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_watch_mode(i_watch_mode),
    .i_sample_valid(i_sample_valid), .o_reg_rdata(o_reg_rdata), .o_wake(o_wake));

// ===== tb/test_motion_wake_threshold_logic.sv
// self-checking bench of the wake logic
`timescale 1ns/100ps
module test_motion_wake_threshold_logic;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_watch_mode = 1'b0, i_sample_valid = 1'b0;
    logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
    logic [11:0] i_sample_x = 12'h000, i_sample_y = 12'h000, i_sample_z = 12'h000;
    logic o_wake;
    int num_errors = 0, n_compared = 0;
    motion_wake_threshold_logic #(.SW(12)) i_motion_wake_threshold_logic (.i_clk(i_clk),
        .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_watch_mode(i_watch_mode),
        .i_sample_valid(i_sample_valid), .i_sample_x(i_sample_x), .i_sample_y(i_sample_y),
        .i_sample_z(i_sample_z), .o_reg_rdata(o_reg_rdata), .o_wake(o_wake));
    initial forever #10 i_clk = ~i_clk;
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one idle edge between accesses keeps each strobe to one driver step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge i_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        @(negedge i_clk);
        q = o_reg_rdata;
    endtask
    task automatic smp(input logic [11:0] x, y, z, input logic e);
        @(posedge i_clk);
        i_sample_valid <= 1'b1;
        i_sample_x <= x;
        i_sample_y <= y;
        i_sample_z <= z;
        @(posedge i_clk);
        i_sample_valid <= 1'b0;
        repeat (3) @(posedge i_clk);
        #1 chk({7'h00, o_wake}, {7'h00, e});
    endtask
    // z threshold rides in tc; first sample of each entry is the reference
    task automatic run(input logic [7:0] ctl, tc, cfg, input logic [11:0] x1, y1, z1,
                       input logic e1, input logic [11:0] x2, y2, z2, input logic e2);
        wr(8'h10, ctl);
        wr(8'h14, cfg);
        wr(8'h13, tc);
        @(posedge i_clk);
        i_watch_mode <= 1'b1;
        smp(12'h000, 12'h000, 12'h000, 1'b0);
        smp(x1, y1, z1, e1);
        smp(x2, y2, z2, e2);
        @(posedge i_clk);
        i_watch_mode <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////
    // power-on values, then plain readback of control and config
    task automatic test_reset;
        logic [7:0] q;
        rd(8'h13, q);
        chk(q, 8'h00);
        rd(8'h10, q);
        chk(q, 8'h00);
        rd(8'h14, q);
        chk(q, 8'h00);
        wr(8'h10, 8'h50);
        rd(8'h10, q);
        chk(q, 8'h50);
        wr(8'h14, 8'h0D);
        rd(8'h14, q);
        chk(q, 8'h0D);
    endtask
    task automatic test_shadow;
        logic [7:0] q;
        for (int s = 0; s < 8; s++) begin
            wr(8'h14, 8'(s));
            wr(8'h13, 8'(s * 9));
            rd(8'h13, q);
            chk(q, (s == 0 || s == 4) ? 8'h00 : 8'(s * 9));
        end
        for (int s = 0; s < 8; s++) begin
            wr(8'h14, 8'(s));
            rd(8'h13, q);
            chk(q, (s == 0 || s == 4) ? 8'h00 : 8'(s * 9));
        end
        rd(8'h20, q);
        chk(q, 8'h00);
    endtask
    task automatic test_or_pd;
        wr(8'h14, 8'h01);
        wr(8'h13, 8'h0A);
        wr(8'h14, 8'h02);
        wr(8'h13, 8'h0A);
        run(8'h00, 8'h0A, 8'h03, 0, 0, 10, 0, 0, 0, 21, 1);
        run(8'h40, 8'h0A, 8'h03, 0, 0, 10, 0, 0, 0, 21, 0);
        run(8'h70, 8'h0A, 8'h03, 0, 0, 21, 0, 21, 21, 42, 0);
    endtask
    task automatic test_and;
        run(8'h00, 8'h4A, 8'h03, 0, 0, 21, 0, 21, 21, 21, 1);
        run(8'h30, 8'h4A, 8'h03, 0, 0, 21, 1, 0, 0, 21, 1);
    endtask
    task automatic test_delta_mode;
        run(8'h00, 8'h0A, 8'h03, 0, 0, 8, 0, 0, 0, 16, 0);
        run(8'h00, 8'h8A, 8'h03, 0, 0, 8, 0, 0, 0, 16, 1);
    endtask
    task automatic test_count;
        wr(8'h14, 8'h07);
        wr(8'h13, 8'h01);
        run(8'h00, 8'h0A, 8'h0B, 0, 0, 21, 0, 0, 0, 42, 1);
        run(8'h00, 8'h0A, 8'h0B, 0, 0, 21, 0, 0, 0, 42, 1);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("errors %0d compares %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        test_reset;
        test_shadow;
        test_or_pd;
        test_and;
        test_delta_mode;
        test_count;
        end_of_test;
    end
    // the whole sequence needs well under a thousand cycles
    initial begin
        #200000;
        num_errors++;
        end_of_test;
    end
endmodule
